// *** rtl/io_cell.sv ***
// One configurable I/O cell with an AXI4-Lite configuration port.
// Assumes pin and user inputs are synchronous to aclk; the pin wire is
// resolved outside from pin_out, pin_oe and pull_up_en.
`timescale 1ns/10ps
`include "io_cell_regs.svh"
module io_cell
    import io_cell_pkg::*;
#(
    parameter int SOFT_START_CYCLES = `SOFT_START_CYCLES
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Device state
    input wire logic chip_reset_n,
    input wire logic config_busy,
    // Die edge clock lines
    input wire logic [1:0] edge_clk_line,
    // Package pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up_en,
    output logic slew_fast,
    // Internal user logic side
    input wire logic out_data,
    input wire logic tri_ctrl,
    output logic in_direct,
    output logic in_stored,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Byte-lane merge, used for both writable registers
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_lanes

    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] off
    );
        return addr[7:2] == off[7:2];
    endfunction : addr_hit

    // Same choice for input and output storage, so one helper
    function automatic line_evt_t pick_line(
        input line_evt_t line0,
        input line_evt_t line1,
        input logic sel
    );
        return sel ? line1 : line0;
    endfunction : pick_line

    // Unmapped offsets answer with a decode error on both channels
    function automatic logic [1:0] resp_code(input logic hit);
        return hit ? RESP_OKAY : RESP_DECERR;
    endfunction : resp_code

    // Configuration state
    cfg_t cfg_q;
    logic [1:0] clkpol_q;

    // Decoded configuration fields, named for the paths they steer
    wire in_latch_mode = cfg_q.in_latch;
    wire out_reg_mode = cfg_q.out_registered;
    wire out_inv = cfg_q.out_invert;
    wire tri_inv = cfg_q.tri_invert;
    wire pullup_cfg = cfg_q.pullup_en;
    wire slew_cfg = cfg_q.slew_fast;

    // Bus state
    wr_state_t wr_state_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Cell state
    logic out_q;
    logic soft_start_q;
    logic [15:0] soft_cnt_q;

    // Clock lines
    line_evt_t line_evt [2];
    line_evt_t in_evt;
    line_evt_t out_evt;

    // One edge detector per line; input and output stores choose between them
    for (genvar g = 0; g < 2; g++) begin : g_line
        clock_line_unit u_line (
            .aclk(aclk),
            .aresetn(aresetn),
            .line(edge_clk_line[g]),
            .invert(clkpol_q[g]),
            .evt(line_evt[g])
        );
    end

    assign in_evt = pick_line(line_evt[0], line_evt[1], cfg_q.in_clk_sel);
    assign out_evt = pick_line(line_evt[0], line_evt[1], cfg_q.out_clk_sel);

    // Storage is cleared by configuration or the chip reset pin
    wire clear_stores = config_busy | ~chip_reset_n;

    // Input path
    wire stored_in;

    input_store u_in_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(clear_stores),
        .latch_mode(in_latch_mode),
        .evt(in_evt),
        .d(pin_in),
        .q(stored_in)
    );

    // Both input views at once
    assign in_direct = pin_in;
    assign in_stored = stored_in;

    // Output register on the positive edge of the chosen line;
    // a clear wins over a capture in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_stores) begin
            out_q <= 1'b0;
        end else if (out_evt.pulse) begin
            out_q <= out_data;
        end
    end

    wire out_src = out_reg_mode ? out_q : out_data;
    assign pin_out = out_src ^ out_inv;

    // Control high floats the pin unless sense is inverted
    wire ctrl_enable = tri_inv ? tri_ctrl : ~tri_ctrl;
    logic oe_sel;

    // Open drain needs out_data and tri_ctrl tied together outside
    always_comb begin
        unique case (cfg_q.oe_mode)
            OE_BY_CTRL: oe_sel = ctrl_enable;
            OE_ON: oe_sel = 1'b1;
            OE_OFF: oe_sel = 1'b0;
            default: oe_sel = 1'b0;
        endcase
    end

    // No drive at all while the device is still being configured
    assign pin_oe = oe_sel & ~config_busy;

    // Pull-up yields whenever the cell drives
    assign pull_up_en = pullup_cfg & ~pin_oe;

    // Soft startup: slow edges until outputs have been on for a while,
    // so a bank of outputs turning on together cannot bounce ground.
    // The count only runs while the pin is driven, so a cell that never
    // drives stays slow; the 16-bit counter caps SOFT_START_CYCLES at 65536.
    always_ff @(posedge aclk) begin
        if (!aresetn || config_busy) begin
            soft_start_q <= 1'b1;
            soft_cnt_q <= 16'h0000;
        end else if (soft_start_q && pin_oe) begin
            if (soft_cnt_q == 16'(SOFT_START_CYCLES - 1)) begin
                soft_start_q <= 1'b0;
            end
            soft_cnt_q <= soft_cnt_q + 16'h0001;
        end
    end

    assign slew_fast = slew_cfg & ~soft_start_q;

    // Write channel: address and data may come in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_got_q | aw_take;
    wire have_w = w_got_q | w_take;
    wire [7:0] wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
    wire do_write = (wr_state_q == WR_IDLE) & have_aw & have_w;
    wire wr_cfg = do_write & addr_hit(wr_addr, `CFG_OFF);
    wire wr_pol = do_write & addr_hit(wr_addr, `CLKPOL_OFF);
    wire wr_stat = do_write & addr_hit(wr_addr, `STATUS_OFF);
    wire wr_hit = wr_cfg | wr_pol | wr_stat;

    assign s_axi_awready = (wr_state_q == WR_IDLE) & ~aw_got_q;
    assign s_axi_wready = (wr_state_q == WR_IDLE) & ~w_got_q;
    assign s_axi_bvalid = (wr_state_q == WR_RESP);
    assign s_axi_bresp = bresp_q;

    // Register images padded to the bus width
    wire [31:0] cfg_word = {22'h000000, cfg_q};
    wire [31:0] pol_word = {30'h00000000, clkpol_q};
    wire [31:0] cfg_new = merge_lanes(cfg_word, wr_data, wr_strb);
    wire [31:0] pol_new = merge_lanes(pol_word, wr_data, wr_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end else begin
            unique case (wr_state_q)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state_q <= WR_RESP;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        bresp_q <= resp_code(wr_hit);
                    end else begin
                        if (aw_take) begin
                            aw_got_q <= 1'b1;
                            awaddr_q <= s_axi_awaddr;
                        end
                        if (w_take) begin
                            w_got_q <= 1'b1;
                            wdata_q <= s_axi_wdata;
                            wstrb_q <= s_axi_wstrb;
                        end
                    end
                end
                WR_RESP: begin
                    // Hold the answer until the master takes it
                    if (s_axi_bready) begin
                        wr_state_q <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Configuration registers; pull-up on out of reset.
    // Writes to STATUS are answered OKAY and dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= cfg_t'(`CFG_RESET);
            clkpol_q <= `CLKPOL_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= cfg_t'(cfg_new[`CFG_W-1:0]);
            end
            if (wr_pol) begin
                clkpol_q <= pol_new[1:0];
            end
        end
    end

    // Status view of the cell
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h00000000;
        status_word[`ST_IN_DIRECT] = pin_in;
        status_word[`ST_IN_STORED] = stored_in;
        status_word[`ST_OUT_STORED] = out_q;
        status_word[`ST_PIN_OE] = pin_oe;
        status_word[`ST_SOFT_START] = soft_start_q;
        status_word[`ST_SLEW_FAST] = slew_fast;
    end

    // Read channel: one read in flight, answer one cycle after the take.
    // arready drops while an answer waits, so a second read cannot
    // overwrite rdata_q before the master has taken it.
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_cfg = addr_hit(s_axi_araddr, `CFG_OFF);
    wire rd_pol = addr_hit(s_axi_araddr, `CLKPOL_OFF);
    wire rd_stat = addr_hit(s_axi_araddr, `STATUS_OFF);
    wire rd_hit = rd_cfg | rd_pol | rd_stat;
    wire [31:0] rd_mux = rd_cfg ? cfg_word :
                         rd_pol ? pol_word :
                         rd_stat ? status_word : 32'h00000000;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= resp_code(rd_hit);
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : io_cell

// *** rtl/io_cell_regs.svh ***
// Register map, field positions, reset values and timing for the io_cell.
// Assumes a 32-bit AXI4-Lite register bus clocked at 100 MHz.
//
// Function
// - Two clock lines per die edge, each with its own programmable polarity.
// - Input storage element works as edge flip-flop or level latch on the pin.
// - Rising-edge line makes its latches low-transparent; falling-edge makes them high.
// - All storage cleared during configuration and while global active-low reset is low.
// - Direct pin value and stored input value are both presented at once.
// - Output buffer fed directly or through a positive-edge output register.
// - Output register clock picks either edge line, each through an invertible buffer.
// - One bit per cell inverts the output data before the buffer.
// - Buffer mode is always on, always off, or under three-state control.
// - Default sense: control high floats the pin, control low drives it.
// - An extra bit inverts the control sense into an active-high enable.
// - First output enabling after configuration always uses the slow rate.
// - After startup each output uses its own fast or slow rate bit.
// - Internal pull-up is enabled by default.
// - Pull-up only acts while the cell is not driving the pin.
`ifndef IO_CELL_REGS_SVH
`define IO_CELL_REGS_SVH

`define CFG_OFF 8'h00
`define CLKPOL_OFF 8'h04
`define STATUS_OFF 8'h08

`define CFG_W 10
`define CFG_RESET 10'h200
`define CLKPOL_RESET 2'h0

`define ST_IN_DIRECT 0
`define ST_IN_STORED 1
`define ST_OUT_STORED 2
`define ST_PIN_OE 3
`define ST_SOFT_START 4
`define ST_SLEW_FAST 5

`define CLK_PERIOD_NS 10
`define SOFT_START_NS 1000
`define SOFT_START_CYCLES ((`SOFT_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/io_cell_pkg.sv ***
// Types shared by the io_cell design files.
// Field layouts match the bit positions kept in io_cell_regs.svh.
package io_cell_pkg;

    typedef enum logic [1:0] {
        OE_BY_CTRL = 2'b00,
        OE_ON = 2'b01,
        OE_OFF = 2'b10
    } oe_mode_t;

    // Bit 0 is in_latch, bit 9 is pullup_en
    typedef struct packed {
        logic pullup_en;
        logic slew_fast;
        logic tri_invert;
        oe_mode_t oe_mode;
        logic out_invert;
        logic out_clk_sel;
        logic out_registered;
        logic in_clk_sel;
        logic in_latch;
    } cfg_t;

    // Per clock line: edge pulse and latch transparency
    typedef struct packed {
        logic pulse;
        logic transparent;
    } line_evt_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;

endpackage : io_cell_pkg

// *** rtl/clock_line_unit.sv ***
// One die-edge clock line with programmable polarity.
// Line is sampled as a plain synchronous input of aclk.
`timescale 1ns/10ps
module clock_line_unit
    import io_cell_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Line and polarity
    input wire logic line,
    input wire logic invert,
    // Events for the storage elements
    output line_evt_t evt
);
    logic eff;
    logic prev_q;

    // Polarity lives on the line, so every element on it sees the same sense
    assign eff = line ^ invert;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= eff;
        end
    end

    assign evt.pulse = eff & ~prev_q;
    assign evt.transparent = ~eff;
endmodule : clock_line_unit

// *** rtl/input_store.sv ***
// Input storage element, flip-flop or latch, on the buffered pin value.
// Edges and transparency come from clock_line_unit.
`timescale 1ns/10ps
module input_store
    import io_cell_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic clear,
    input wire logic latch_mode,
    input line_evt_t evt,
    // Data
    input wire logic d,
    output logic q
);
    logic q_q;
    logic q_d;

    assign q_d = latch_mode ? (evt.transparent ? d : q_q)
                            : (evt.pulse ? d : q_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_q <= 1'b0;
        end else if (clear) begin
            q_q <= 1'b0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule : input_store

// *** testbench/io_cell_assertions.sv ***
// Concurrent checks on the io_cell pad, user and reset ports.
// Assumes one aclk domain; bound into every io_cell instance.
`timescale 1ns/10ps
module io_cell_assertions #(
    parameter int SOFT_START_CYCLES = 100
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Device state
    input wire logic chip_reset_n,
    input wire logic config_busy,
    // Pad and user side
    input wire logic pin_in,
    input wire logic pin_oe,
    input wire logic pull_up_en,
    input wire logic slew_fast,
    input wire logic tri_ctrl,
    input wire logic in_direct,
    input wire logic in_stored
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Cumulative count, so it only bounds the early end of soft start
    logic [15:0] on_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || config_busy) begin
            on_q <= 16'h0;
        end else if (pin_oe && on_q != 16'hFFFF) begin
            on_q <= on_q + 16'h1;
        end
    end
    direct_path_a: assert property (in_direct == pin_in)
        else $error("direct input differs from pin");
    store_clear_a: assert property (!chip_reset_n || config_busy |=> !in_stored)
        else $error("input store not cleared");
    busy_float_a: assert property (config_busy [*2] |-> !pin_oe)
        else $error("pin driven during configuration");
    pullup_input_a: assert property (pull_up_en |-> !pin_oe)
        else $error("pull-up on while driving");
    pullup_default_a: assert property ($rose(aresetn) |-> pull_up_en != pin_oe)
        else $error("pull-up not on by default");
    reset_sense_a: assert property (
        $rose(aresetn) && !config_busy |-> pin_oe == !tri_ctrl)
        else $error("default three-state sense wrong");
    busy_slow_a: assert property (config_busy |=> !slew_fast)
        else $error("fast slew right after configuration");
    soft_start_a: assert property (slew_fast |-> on_q >= SOFT_START_CYCLES)
        else $error("soft start ended early");
    cover property ($fell(config_busy));
    cover property ($rose(slew_fast));
    cover property ($fell(in_stored));
endmodule : io_cell_assertions

bind io_cell io_cell_assertions #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .chip_reset_n(chip_reset_n), .config_busy(config_busy),
    .pin_in(pin_in), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .slew_fast(slew_fast),
    .tri_ctrl(tri_ctrl), .in_direct(in_direct), .in_stored(in_stored)
);

// *** testbench/pin_model.sv ***
// Board-side model of the package pin with an optional external driver.
// Assumes drive_en is raised only while the cell's buffer is off.
`timescale 1ns/10ps
module pin_model (
    // Clock
    input wire logic aclk,
    // Cell pad side
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pull_up_en,
    // Board driver
    input wire logic drive_en,
    input wire logic drive_val,
    // Level at the input buffer
    output logic pin_in
);
    logic last_q = 1'h0;
    // Floating and unpulled: inverse of the last level, never a lucky match
    assign pin_in = pin_oe ? pin_out : drive_en ? drive_val : pull_up_en ? 1'h1 : ~last_q;
    always @(posedge aclk) begin
        last_q <= pin_in;
    end
endmodule : pin_model

// *** testbench/io_cell_bench.sv ***
// Self-checking bench for io_cell: bus master tasks and one task per scenario.
// Assumes pin_model on the pad and the bound checker; soft start shortened.
`timescale 1ns/10ps
`include "io_cell_regs.svh"
module io_cell_bench;
    logic aclk = 1'h0, aresetn = 1'h0, chip_reset_n = 1'h1, config_busy = 1'h0;
    logic [1:0] edge_clk_line = 2'h0, s_axi_bresp, s_axi_rresp, resp;
    logic out_data = 1'h0, tri_ctrl = 1'h1, drive_en = 1'h0, drive_val = 1'h0;
    logic pin_in, pin_out, pin_oe, pull_up_en, slew_fast, in_direct, in_stored;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int num_errors = 0, tests_run = 0, cycles = 0;

    always #5 aclk = ~aclk;
    io_cell #(.SOFT_START_CYCLES(4)) u_dut (
        .aclk, .aresetn, .chip_reset_n, .config_busy, .edge_clk_line, .pin_in, .pin_out,
        .pin_oe, .pull_up_en, .slew_fast, .out_data, .tri_ctrl, .in_direct, .in_stored,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    pin_model u_pin (.aclk, .pin_out, .pin_oe, .pull_up_en, .drive_en, .drive_val, .pin_in);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : wt

    // Ready and valid are sampled mid-cycle, acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            rv = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tr);
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic cfg(input logic [9:0] v);
        wr(`CFG_OFF, {22'h0, v});
    endtask : cfg

    task automatic t_bus;
        rd(`CFG_OFF);
        chk(rv, `CFG_RESET);
        rd(`CLKPOL_OFF);
        chk(rv, 32'h0);
        rd(`STATUS_OFF);
        chk(rv, (32'h1 << `ST_IN_DIRECT) | (32'h1 << `ST_SOFT_START));
        rd(8'h0C);
        chk(rv, 32'h0);
        chk(resp, 32'h3);
        wr(8'h0C, 32'hFFFFFFFF);
        chk(resp, 32'h3);
        wr(`STATUS_OFF, 32'hFFFFFFFF);
        chk(resp, 32'h0);
        rd(`CFG_OFF);
        chk(rv, `CFG_RESET);
        $display("register reset test done");
    endtask : t_bus

    task automatic t_rst;
        cfg(10'h0E5);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`CFG_OFF);
        chk(rv, `CFG_RESET);
        chk({pin_oe, pull_up_en, slew_fast}, 32'h2);
        $display("mid-run reset test done");
    endtask : t_rst

    task automatic t_oe;
        logic e;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                cfg({2'h2, k[1], m[1:0], 5'h00});
                @(posedge aclk);
                tri_ctrl <= k[0];
                out_data <= k[0];
                wt(1);
                e = m == 1 || (m == 0 && k[0] == k[1]);
                chk({pin_oe, pull_up_en}, {e, !e});
                chk(pin_in, e ? k[0] : 1'h1);
            end
        end
        $display("buffer mode test done");
    endtask : t_oe

    task automatic t_out;
        for (int k = 0; k < 4; k++) begin
            cfg({5'h11, k[0], 4'h0});
            @(posedge aclk);
            out_data <= k[1];
            wt(1);
            chk(pin_out, k[1] ^ k[0]);
        end
        cfg({5'h11, 5'h0C});
        wt(2);
        chk(pin_out, 1'h0);
        @(posedge aclk);
        edge_clk_line <= 2'h2;
        wt(3);
        chk(pin_out, 1'h1);
        wr(`CLKPOL_OFF, 32'h2);
        @(posedge aclk);
        out_data <= 1'h0;
        wt(3);
        chk(pin_out, 1'h1);
        @(posedge aclk);
        edge_clk_line <= 2'h0;
        wt(3);
        chk(pin_out, 1'h0);
        wr(`CLKPOL_OFF, 32'h0);
        $display("output path test done");
    endtask : t_out

    task automatic t_in;
        cfg({5'h12, 5'h00});
        @(posedge aclk);
        drive_en <= 1'h1;
        edge_clk_line <= 2'h1;
        wt(3);
        chk(in_stored, 1'h0);
        @(posedge aclk);
        drive_val <= 1'h1;
        edge_clk_line <= 2'h0;
        wt(3);
        chk({in_direct, in_stored}, 2'h2);
        @(posedge aclk);
        edge_clk_line <= 2'h1;
        wt(3);
        chk(in_stored, 1'h1);
        cfg({5'h12, 5'h01});
        @(posedge aclk);
        drive_val <= 1'h0;
        wt(3);
        chk(in_stored, 1'h1);
        wr(`CLKPOL_OFF, 32'h1);
        wt(2);
        chk(in_stored, 1'h0);
        @(posedge aclk);
        drive_val <= 1'h1;
        wt(2);
        chk(in_stored, 1'h1);
        wr(`CLKPOL_OFF, 32'h0);
        @(posedge aclk);
        chip_reset_n <= 1'h0;
        @(posedge aclk);
        chip_reset_n <= 1'h1;
        wt(2);
        chk(in_stored, 1'h0);
        $display("input store test done");
    endtask : t_in

    task automatic t_slew;
        @(posedge aclk);
        drive_en <= 1'h0;
        cfg({5'h19, 5'h00});
        @(posedge aclk);
        config_busy <= 1'h1;
        wt(2);
        chk(pin_oe, 1'h0);
        @(posedge aclk);
        config_busy <= 1'h0;
        wt(1);
        chk(slew_fast, 1'h0);
        wt(8);
        chk(slew_fast, 1'h1);
        cfg({5'h11, 5'h00});
        wt(1);
        chk(slew_fast, 1'h0);
        $display("slew test done");
    endtask : t_slew

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_bus();
        t_oe();
        t_out();
        t_in();
        t_slew();
        t_rst();
        tally_and_finish();
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
endmodule : io_cell_bench
